/* core/cnv_clock_test.v */
// converter clock selection, data sampling, loopbacks and pattern test
// assumes: apb master on sys_clk; all pin inputs asynchronous to sys_clk
//
// Behaviour
// R1: two switches pick internal, external or network timing
// R2: front-panel test enable on ignores panel tests
// R3: terminal loop request honoured only when switch off
// R4: remote loop requests honoured only when switch off
// R5: sample switch picks external or own transmit clock
// R6: move serial data both ways at 64 kbit/s
// R7: local loop, remote loop, 511 pattern tests
// R8: back-to-back units: one internal/external, other network
// R9: line driven with alternate mark inversion coding
// R10: local loop returns terminal data to terminal
// R11: nine-stage 511 sequence, errors injected periodically
`timescale 1ns/1ps
`include "cnv_defs.vh"
module cnv_clock_test (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        terminal_external_clock,
  input  wire        terminal_transmit_data,
  input  wire        terminal_loop_request,
  input  wire        network_clock,
  input  wire        line_rx_pos,
  input  wire        line_rx_neg,
  input  wire        remote_loop_request,
  output reg         device_transmit_clock,
  output reg         terminal_receive_data,
  output reg         test_mode_lines,
  output reg         line_tx_pos,
  output reg         line_tx_neg,
  output reg         remote_loop_command
);
  // pin synchronisers
  reg  [6:0]  pin_meta_reg;
  reg  [6:0]  pin_sync_reg;
  reg  [6:0]  pin_prev_reg;
  wire [6:0]  pin_raw;
  wire        xc_rise;
  wire        nc_rise;
  wire        td_bit;
  wire        term_req;
  wire        rx_line_bit;
  wire        remote_req;

  // configuration and test registers
  reg  [5:0]  cfg_reg;
  reg  [3:0]  test_reg;
  reg  [15:0] errcnt_reg;
  reg  [15:0] errcnt_next;
  reg         overrun_reg;
  reg         overrun_next;

  // timing
  reg  [10:0] div_reg;
  wire        int_tick;
  reg         tx_tick;
  wire        rx_tick;
  wire        samp_tick;
  wire [1:0]  clk_mode;

  // data path
  reg         pend_valid_reg;
  reg         pend_bit_reg;
  wire        fifo_in_ready;
  wire        fifo_out_data;
  wire        fifo_out_valid;
  wire [3:0]  fifo_level;
  wire        fifo_bit;
  reg         rx_bit_reg;
  reg         ami_pol_reg;
  reg         line_bit;

  // test modes
  wire        fp_en;
  wire        local_loop;
  wire        rl_send;
  wire        rl_serve;
  wire        pattern_on;
  wire        inject_on;
  reg  [8:0]  gen_reg;
  reg  [9:0]  inj_cnt_reg;
  wire        inj_now;
  reg  [8:0]  chk_reg;
  reg  [3:0]  run_reg;
  wire        chk_match;
  wire        psync;

  // apb
  wire [5:0]  word_addr;
  wire        apb_access;
  wire        apb_write;
  wire        mapped;
  reg  [31:0] read_mux;

  assign pin_raw = {remote_loop_request, line_rx_neg, line_rx_pos, network_clock,
                    terminal_loop_request, terminal_transmit_data,
                    terminal_external_clock};

  always @(posedge sys_clk) begin
    if (srst) begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
      pin_prev_reg <= 7'h00;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign xc_rise     = pin_sync_reg[0] & ~pin_prev_reg[0];
  assign td_bit      = pin_sync_reg[1];
  assign term_req    = pin_sync_reg[2];
  assign nc_rise     = pin_sync_reg[3] & ~pin_prev_reg[3];
  assign rx_line_bit = pin_sync_reg[4] | pin_sync_reg[5];
  assign remote_req  = pin_sync_reg[6];

  // internal 64 kbit/s bit clock
  always @(posedge sys_clk) begin
    if (srst) begin
      div_reg <= 11'h000;
    end else if (div_reg == `CNV_DIV_LAST) begin
      div_reg <= 11'h000;
    end else begin
      div_reg <= div_reg + 11'h001;
    end
  end

  assign int_tick = (div_reg == `CNV_DIV_LAST); // see R6
  assign clk_mode = {cfg_reg[`CNV_CFG_CLK_HIGH], cfg_reg[`CNV_CFG_CLK_LOW]};

  // transmit timing source
  always @* begin
    case (clk_mode) // see R1
      `CNV_MODE_INTERNAL: tx_tick = int_tick;
      `CNV_MODE_EXTERNAL: tx_tick = xc_rise;
      `CNV_MODE_NET_NORMAL: tx_tick = nc_rise;
      `CNV_MODE_NET_CAMPUS: tx_tick = nc_rise;
      default: tx_tick = int_tick;
    endcase
  end

  // campus mode takes received bits on the transmit tick
  assign rx_tick = (clk_mode == `CNV_MODE_NET_CAMPUS) ? tx_tick : nc_rise;

  // terminal data sampling clock
  assign samp_tick = cfg_reg[`CNV_CFG_SAMPLE] ? xc_rise : tx_tick; // see R5

  // test mode gating
  assign fp_en      = ~cfg_reg[`CNV_CFG_FP_EN]; // see R2
  assign local_loop = (fp_en & test_reg[`CNV_TST_LOCAL]) |
                      (~cfg_reg[`CNV_CFG_TERM_REQ] & term_req); // see R3
  assign rl_send    = fp_en & test_reg[`CNV_TST_REMOTE]; // see R7
  assign rl_serve   = ~cfg_reg[`CNV_CFG_RL_RESP] & remote_req; // see R4
  assign pattern_on = fp_en & test_reg[`CNV_TST_PATTERN]; // see R7
  assign inject_on  = pattern_on & test_reg[`CNV_TST_INJECT];

  // sampled bit waits here until the fifo takes it
  always @(posedge sys_clk) begin
    if (srst) begin
      pend_valid_reg <= 1'b0;
      pend_bit_reg   <= 1'b0;
    end else if (samp_tick & (~pend_valid_reg | fifo_in_ready)) begin
      pend_valid_reg <= 1'b1;
      pend_bit_reg   <= td_bit;
    end else if (fifo_in_ready) begin
      pend_valid_reg <= 1'b0;
    end
  end

  cnv_fifo #(
    .WIDTH (1),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_data   (pend_bit_reg),
    .in_valid  (pend_valid_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (tx_tick),
    .level     (fifo_level)
  );

  // idle line sends marks
  assign fifo_bit = fifo_out_valid ? fifo_out_data : 1'b1;

  // pattern generator and error injection
  assign inj_now = inject_on & (inj_cnt_reg == `CNV_INJ_LAST); // see R11

  always @(posedge sys_clk) begin
    if (srst) begin
      gen_reg     <= `CNV_PRBS_SEED;
      inj_cnt_reg <= 10'h000;
    end else if (tx_tick & pattern_on) begin
      gen_reg     <= {gen_reg[7:0], gen_reg[8] ^ gen_reg[4]}; // see R11
      inj_cnt_reg <= inj_cnt_reg + 10'h001;
    end
  end

  // line bit selection
  always @* begin
    if (rl_serve) begin
      line_bit = rx_bit_reg; // see R4
    end else if (pattern_on) begin
      line_bit = gen_reg[8] ^ inj_now; // see R7
    end else begin
      line_bit = fifo_bit; // see R6
    end
  end

  // alternate mark inversion line drive
  always @(posedge sys_clk) begin
    if (srst) begin
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
      ami_pol_reg <= 1'b0;
    end else if (tx_tick) begin
      line_tx_pos <= line_bit & ~ami_pol_reg; // see R9
      line_tx_neg <= line_bit & ami_pol_reg; // see R9
      if (line_bit) begin
        ami_pol_reg <= ~ami_pol_reg;
      end
    end
  end

  // receive side
  always @(posedge sys_clk) begin
    if (srst) begin
      rx_bit_reg <= 1'b1;
    end else if (rx_tick) begin
      rx_bit_reg <= rx_line_bit; // see R6
    end
  end

  // pattern checker
  assign chk_match = (rx_bit_reg == (chk_reg[8] ^ chk_reg[4]));
  assign psync     = (run_reg == `CNV_SYNC_RUN);

  always @(posedge sys_clk) begin
    if (srst) begin
      chk_reg <= 9'h000;
      run_reg <= 4'h0;
    end else if (~pattern_on) begin
      run_reg <= 4'h0;
    end else if (rx_tick) begin
      chk_reg <= {chk_reg[7:0], rx_bit_reg};
      if (~chk_match) begin
        run_reg <= 4'h0;
      end else if (~psync) begin
        run_reg <= run_reg + 4'h1;
      end
    end
  end

  // terminal-facing outputs
  always @(posedge sys_clk) begin
    if (srst) begin
      device_transmit_clock <= 1'b0;
      terminal_receive_data <= 1'b1;
      test_mode_lines       <= 1'b0;
      remote_loop_command   <= 1'b0;
    end else begin
      case (clk_mode) // see R1
        `CNV_MODE_INTERNAL: device_transmit_clock <= (div_reg < `CNV_DIV_HALF);
        `CNV_MODE_EXTERNAL: device_transmit_clock <= pin_sync_reg[0];
        default: device_transmit_clock <= pin_sync_reg[3];
      endcase
      if (tx_tick) begin
        terminal_receive_data <= local_loop ? fifo_bit : rx_bit_reg; // see R10
      end
      test_mode_lines     <= local_loop | rl_send | rl_serve | pattern_on; // see R7
      remote_loop_command <= rl_send; // see R7
    end
  end

  // apb slave: answers on the second access cycle
  assign word_addr  = paddr[7:2];
  assign mapped     = (paddr[11:8] == 4'h0) & (paddr[1:0] == 2'b00) &
                      (word_addr <= `CNV_ADDR_ERRCNT);
  assign apb_access = psel & penable & ~pready;
  assign apb_write  = psel & penable & pready & pwrite & mapped;

  always @* begin
    read_mux = 32'h0000_0000;
    case (word_addr)
      `CNV_ADDR_CONFIG: read_mux[5:0] = cfg_reg;
      `CNV_ADDR_TEST: read_mux[3:0] = test_reg;
      `CNV_ADDR_STATUS: begin
        read_mux[`CNV_ST_LOCAL]   = local_loop;
        read_mux[`CNV_ST_RL_SERVE] = rl_serve;
        read_mux[`CNV_ST_RL_SEND] = rl_send;
        read_mux[`CNV_ST_PATTERN] = pattern_on;
        read_mux[`CNV_ST_PSYNC]   = psync;
        read_mux[`CNV_ST_OVERRUN] = overrun_reg;
        read_mux[`CNV_ST_MODE_LO] = clk_mode[0];
        read_mux[`CNV_ST_MODE_HI] = clk_mode[1];
        read_mux[11:8]            = fifo_level;
      end
      `CNV_ADDR_ERRCNT: read_mux[15:0] = errcnt_reg;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & ~mapped;
      if (apb_access) begin
        prdata <= mapped ? read_mux : 32'h0000_0000;
      end
    end
  end

  // sticky overrun and error count, hardware set wins over clear
  always @* begin
    overrun_next = overrun_reg;
    if (apb_write & (word_addr == `CNV_ADDR_STATUS) & pstrb[0] &
        pwdata[`CNV_ST_OVERRUN]) begin
      overrun_next = 1'b0;
    end
    if (samp_tick & pend_valid_reg & ~fifo_in_ready) begin
      overrun_next = 1'b1;
    end
    errcnt_next = errcnt_reg;
    if (apb_write & (word_addr == `CNV_ADDR_ERRCNT)) begin
      errcnt_next = 16'h0000;
    end
    if (pattern_on & rx_tick & psync & ~chk_match & (errcnt_reg != 16'hFFFF)) begin
      errcnt_next = errcnt_next + 16'h0001; // see R7
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      cfg_reg     <= `CNV_CFG_RESET;
      test_reg    <= `CNV_TST_RESET;
      overrun_reg <= 1'b0;
      errcnt_reg  <= 16'h0000;
    end else begin
      overrun_reg <= overrun_next;
      errcnt_reg  <= errcnt_next;
      if (apb_write & pstrb[0] & (word_addr == `CNV_ADDR_CONFIG)) begin
        cfg_reg <= pwdata[5:0];
      end
      if (apb_write & pstrb[0] & (word_addr == `CNV_ADDR_TEST)) begin
        test_reg <= pwdata[3:0];
      end
    end
  end
endmodule

/* core/cnv_defs.vh */
// constants for the converter clock and test control block
// assumes: included by the design files, 125 MHz system clock
`ifndef CNV_DEFS_VH
`define CNV_DEFS_VH

// timing
`define CNV_SYS_CLK_HZ        125000000
`define CNV_LINE_RATE_BPS     64000
`define CNV_BIT_CYCLES        (`CNV_SYS_CLK_HZ / `CNV_LINE_RATE_BPS)
`define CNV_DIV_LAST          11'd1952
`define CNV_DIV_HALF          11'd976

// register word indexes, byte address is four times the index
`define CNV_ADDR_CONFIG       6'h00
`define CNV_ADDR_TEST         6'h01
`define CNV_ADDR_STATUS       6'h02
`define CNV_ADDR_ERRCNT       6'h03

// config fields
`define CNV_CFG_CLK_LOW       0
`define CNV_CFG_CLK_HIGH      1
`define CNV_CFG_SAMPLE        2
`define CNV_CFG_RL_RESP       3
`define CNV_CFG_FP_EN         4
`define CNV_CFG_TERM_REQ      5
`define CNV_CFG_RESET         6'h00

// test fields
`define CNV_TST_LOCAL         0
`define CNV_TST_REMOTE        1
`define CNV_TST_PATTERN       2
`define CNV_TST_INJECT        3
`define CNV_TST_RESET         4'h0

// status fields
`define CNV_ST_LOCAL          0
`define CNV_ST_RL_SERVE       1
`define CNV_ST_RL_SEND        2
`define CNV_ST_PATTERN        3
`define CNV_ST_PSYNC          4
`define CNV_ST_OVERRUN        5
`define CNV_ST_MODE_LO        6
`define CNV_ST_MODE_HI        7

// clock modes
`define CNV_MODE_INTERNAL     2'b00
`define CNV_MODE_EXTERNAL     2'b01
`define CNV_MODE_NET_NORMAL   2'b10
`define CNV_MODE_NET_CAMPUS   2'b11

// pattern generator, error injection and checker
`define CNV_PRBS_SEED         9'h1FF
`define CNV_INJ_LAST          10'h3FF
`define CNV_SYNC_RUN          4'hF

`endif

/* core/cnv_fifo.v */
// small synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
module cnv_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [AW:0]      level
);
  reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_reg;
  reg  [AW-1:0]    rd_ptr_reg;
  reg  [AW:0]      count_reg;
  wire             push;
  wire             pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign level     = count_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* verif/cnv_ct_assertions.sv */
// assertions on the converter clock and test control block ports
// assumes: config and test shadows rebuilt from completed apb writes
`timescale 1ns/1ps
module cnv_ct_assertions (
  input wire        sys_clk,
  input wire        srst,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        terminal_loop_request,
  input wire        remote_loop_request,
  input wire        test_mode_lines,
  input wire        line_tx_pos,
  input wire        line_tx_neg,
  input wire        remote_loop_command
);
  reg  [5:0] cfg_reg;
  reg  [3:0] tst_reg;
  reg        last_pos_reg;
  wire       wr_hit;

  assign wr_hit = psel && penable && pready && pwrite && paddr[11:3] == 9'h000
                  && paddr[1:0] == 2'h0;

  always @(posedge sys_clk) begin
    if (srst) begin
      cfg_reg      <= 6'h00;
      tst_reg      <= 4'h0;
      last_pos_reg <= 1'b0;
    end else begin
      if (wr_hit && !paddr[2])
        cfg_reg <= pwdata[5:0];
      if (wr_hit && paddr[2])
        tst_reg <= pwdata[3:0];
      if (line_tx_pos)
        last_pos_reg <= 1'b1;
      else if (line_tx_neg)
        last_pos_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  a_tx_exclusive: assert property (!(line_tx_pos && line_tx_neg))
    else $error("both line halves high");
  a_pos_alternates: assert property ($rose(line_tx_pos) |-> !last_pos_reg)
    else $error("two positive marks in a row");
  a_neg_alternates: assert property ($rose(line_tx_neg) |-> last_pos_reg)
    else $error("two negative marks in a row");
  a_term_request: assert property ((terminal_loop_request && !cfg_reg[5])[*6]
    |-> test_mode_lines)
    else $error("terminal loop request ignored");
  a_remote_response: assert property ((remote_loop_request && !cfg_reg[3])[*6]
    |-> test_mode_lines)
    else $error("remote loop request ignored");
  a_panel_send: assert property ((tst_reg[1] && !cfg_reg[4])[*4]
    |-> remote_loop_command && test_mode_lines)
    else $error("panel remote loop not sent");
  a_panel_blocked: assert property (cfg_reg[4][*4] |-> !remote_loop_command)
    else $error("panel control acted while disabled");
  a_tests_idle: assert property (((cfg_reg[4] || tst_reg == 4'h0) &&
    (cfg_reg[5] || !terminal_loop_request) && (cfg_reg[3] || !remote_loop_request))[*6]
    |-> !test_mode_lines)
    else $error("test mode without a cause");
  a_ready_pulse: assert property (pready |=> !pready && !pslverr)
    else $error("apb answer longer than one cycle");
endmodule

bind cnv_clock_test cnv_ct_assertions u_chk (
  .sys_clk              (sys_clk),
  .srst                 (srst),
  .paddr                (paddr),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .pwdata               (pwdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .terminal_loop_request(terminal_loop_request),
  .remote_loop_request  (remote_loop_request),
  .test_mode_lines      (test_mode_lines),
  .line_tx_pos          (line_tx_pos),
  .line_tx_neg          (line_tx_neg),
  .remote_loop_command  (remote_loop_command)
);

/* verif/cnv_dte_model.sv */
// terminal equipment model: supplies clock and data, collects returned bits
// assumes: driven from sys_clk edges; its clock stands low outside frames
`timescale 1ns/1ps
module cnv_dte_model #(
  parameter HALF = 8
) (
  input  wire sys_clk,
  output reg  ext_clk,
  output reg  txd,
  input  wire rxd
);
  logic rq[$];

  initial begin
    ext_clk = 1'b0;
    txd     = 1'b1;
  end

  // msb first, data changes while the clock is low
  task automatic send(input logic [63:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      txd <= bits[i];
      repeat (HALF) @(posedge sys_clk);
      ext_clk <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      ext_clk <= 1'b0;
      rq.push_back(rxd);
    end
    txd <= ~txd;
  endtask
endmodule

/* verif/test_converter_clock_and_test_config.sv */
// self-checking bench for the converter clock and test control block
// assumes: line output looped to line input, terminal model on the data side
`timescale 1ns/1ps
`define chk(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h expected %h", $time, g, e); end end
module test_converter_clock_and_test_config;
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        term_req = 1'b0;
  logic        rem_req  = 1'b0;
  logic [31:0] rd;
  logic        er;
  logic [5:0]  c;
  logic [3:0]  t;
  logic [7:0]  e;
  logic [63:0] w;
  logic        hit;
  logic        m;
  int          hc;
  wire  [31:0] prdata;
  wire         pready, pslverr, ext_clk, txd, dtc, rxd, tml, tpos, tneg, rlc;
  int          err_count = 0;
  int          n_checks  = 0;

  always #4 sys_clk = ~sys_clk;

  cnv_clock_test uut (
    .sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .terminal_external_clock(ext_clk), .terminal_transmit_data(txd),
    .terminal_loop_request(term_req), .network_clock(ext_clk), .line_rx_pos(tpos),
    .line_rx_neg(tneg), .remote_loop_request(rem_req), .device_transmit_clock(dtc),
    .terminal_receive_data(rxd), .test_mode_lines(tml), .line_tx_pos(tpos),
    .line_tx_neg(tneg), .remote_loop_command(rlc)
  );

  cnv_dte_model dte (.sys_clk(sys_clk), .ext_clk(ext_clk), .txd(txd), .rxd(rxd));

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // expected status bits 7:6 and 3:0 from switches, panel bits and pins
  function automatic logic [7:0] smodel(logic [5:0] s, logic [3:0] p, logic l, logic r);
    logic fp;
    fp = !s[4];
    return {s[1:0], 2'b00, p[2] & fp, p[1] & fp, r & !s[3], (p[0] & fp) | (l & !s[5])};
  endfunction

  task automatic report_and_stop;
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(28));
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `chk(rd, 32'h0)
    end
    apb(1'b0, 12'h010, 32'h0);
    `chk({er, rd}, {1'b1, 32'h0})
    for (int k = 0; k < 24; k++) begin
      c = 6'($urandom);
      t = 4'($urandom);
      term_req <= 1'($urandom);
      rem_req  <= 1'($urandom);
      apb(1'b1, 12'h000, {26'h0, c});
      apb(1'b1, 12'h004, {28'h0, t});
      repeat (6) @(posedge sys_clk);
      apb(1'b0, 12'h008, 32'h0);
      e = smodel(c, t, term_req, rem_req);
      `chk(rd[7:0] & 8'hCF, e)
      `chk(tml, |e[3:0])
      `chk(rlc, e[2])
      apb(1'b0, 12'h000, 32'h0);
      `chk(rd, {26'h0, c})
    end
    term_req <= 1'b0;
    rem_req  <= 1'b0;
    apb(1'b1, 12'h000, 32'h05);
    apb(1'b1, 12'h004, 32'h01);
    w = {$urandom, $urandom};
    dte.send(w, 40);
    hit = 1'b0;
    for (int j = 0; j + 24 <= dte.rq.size(); j++) begin
      m = 1'b1;
      for (int b = 0; b < 24; b++)
        if (dte.rq[j + b] !== w[39 - b])
          m = 1'b0;
      hit = hit | m;
    end
    `chk(hit, 1'b1)
    apb(1'b1, 12'h004, 32'h00);
    apb(1'b1, 12'h000, 32'h04);
    dte.send(w, 12);
    apb(1'b0, 12'h008, 32'h0);
    `chk({rd[11:8], rd[5]}, {4'h8, 1'b1})
    apb(1'b1, 12'h008, 32'h20);
    apb(1'b0, 12'h008, 32'h0);
    `chk(rd[5], 1'b0)
    hc = 0;
    for (int i = 0; i < 18000; i++) begin
      @(posedge sys_clk);
      if (i < 1953)
        hc = hc + int'(dtc);
    end
    `chk(hc, 976)
    apb(1'b0, 12'h008, 32'h0);
    `chk(rd[11:8], 4'h0)
    apb(1'b1, 12'h000, 32'h01);
    apb(1'b1, 12'h004, 32'h04);
    repeat (2) dte.send(w, 64);
    apb(1'b0, 12'h008, 32'h0);
    `chk(rd[4:3], 2'h3)
    apb(1'b0, 12'h00C, 32'h0);
    `chk(rd, 32'h0)
    apb(1'b1, 12'h004, 32'h0C);
    repeat (17) dte.send(w, 64);
    apb(1'b0, 12'h00C, 32'h0);
    `chk(rd, 32'h1)
    report_and_stop();
  end
endmodule
